// file: verilog/sfc_startup_ctrl.sv
`timescale 1ns/100ps
// Purpose: fabric-facing startup, pin takeover and program-event control
// Assumes: all inputs synchronous to clk, clock-like inputs sampled as data
// Notes: clock pins are modelled as sampled levels driven from flops
module sfc_startup_ctrl (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic userStartupClk,
  input wire logic globalSetReset,
  input wire logic globalTristate,
  input wire logic userCfgClockOut,
  input wire logic userCfgClockTristate,
  input wire logic userDoneOut,
  input wire logic userDoneTristate,
  input wire logic cfgClockPinIn,
  input wire logic flashDataPinIn,
  input wire logic internalOscIn,
  input wire logic mainCfgClkIn,
  input wire logic programPinPulse,
  input wire logic scanProgramCommand,
  input wire logic reprogramAcknowledge,
  input wire logic keyClear_n,
  input wire logic programSecurityEnable,
  output logic endOfStartup,
  output logic flopInitLoad,
  output logic userIoFloat,
  output logic cfgClockPinOut,
  output logic cfgClockPinOe,
  output logic donePinOut,
  output logic donePinOe,
  output logic cfgClockEcho,
  output logic flashSerialDataEcho,
  output logic internalOscillatorClock,
  output logic mainConfigurationClock,
  output logic reprogramRequest,
  output logic deviceReset,
  output logic keyEraseStrobe
);
  import sfc_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  logic startStep; // rising edge of fabric startup clock
  logic [SCNT_W-1:0] stepCnt_ff; // startup sequence position
  logic [SCNT_W-1:0] nxt_stepCnt;
  logic startDone_ff; // internal end-of-startup flag
  logic nxt_startDone; // next value of the startup flag
  sfc_prog_t progState_ff; // program event machine
  sfc_prog_t nxt_progState;
  logic progEvent; // any program source
  logic secOn; // security feature active
  logic [KCNT_W-1:0] keyCnt_ff; // low time of key clear
  logic [KCNT_W-1:0] nxt_keyCnt;
  logic keyDone_ff; // erase already fired this pulse
  logic keyHit; // threshold reached this cycle
  logic flopLoad_ff; // registered global set/reset
  logic ioFloat_ff; // registered global tristate
  logic clkPinOut_ff; // config clock pin value
  logic clkPinOe_ff; // config clock pin driven when high
  logic doneO_ff; // done pin value
  logic doneOe_ff; // done pin driven when high
  logic clkEcho_ff; // config clock copy for the fabric
  logic dinEcho_ff; // flash data copy for the fabric
  logic oscEcho_ff; // oscillator copy
  logic cfgEcho_ff; // main config clock copy
  logic req_ff; // reprogram request to the fabric
  logic rst_ff; // one-cycle reset pulse
  logic erase_ff; // one-cycle key erase strobe

  // saturating increment keeps a long low pulse from wrapping the count
  function automatic logic [KCNT_W-1:0] satInc(input logic [KCNT_W-1:0] v,
                                                input logic [KCNT_W-1:0] lim);
    satInc = (v >= lim) ? lim : v + 5'h01;
  endfunction : satInc

  // ****************************************
  // startup sequencer
  // ****************************************
  sfc_edge_sync uStartEdge (
    .clk(clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .sigIn(userStartupClk),
    .riseOut(startStep)
  );

  // sequence steps only on the fabric clock edge; program reset restarts it
  assign nxt_stepCnt = rst_ff ? 4'h0 :
                       (startStep && !startDone_ff) ? stepCnt_ff + 4'h1 : stepCnt_ff;
  assign nxt_startDone = rst_ff ? 1'b0 :
                         (stepCnt_ff == SCNT_W'(START_STEPS - 1) && startStep) ? 1'b1 :
                         startDone_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stepCnt_ff <= 4'h0;
      startDone_ff <= 1'b0;
    end else if (clkEn) begin
      stepCnt_ff <= nxt_stepCnt;
      startDone_ff <= nxt_startDone;
    end
  end
  assign endOfStartup = startDone_ff;

  // ****************************************
  // program event handshake
  // ****************************************
  assign secOn = programSecurityEnable;
  assign progEvent = programPinPulse | scanProgramCommand;

  // with security off the reset proceeds at once, no request is raised
  always_comb begin
    nxt_progState = progState_ff;
    case (progState_ff)
      PS_IDLE: begin
        if (progEvent) begin
          nxt_progState = secOn ? PS_REQ : PS_RESET;
        end
      end
      PS_REQ: begin
        if (reprogramAcknowledge || !secOn) begin
          nxt_progState = PS_RESET;
        end
      end
      PS_RESET: begin
        nxt_progState = PS_RESTART;
      end
      PS_RESTART: begin
        nxt_progState = PS_IDLE;
      end
      default: begin
        nxt_progState = PS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      progState_ff <= PS_IDLE;
      req_ff <= 1'b0;
      rst_ff <= 1'b0;
    end else if (clkEn) begin
      progState_ff <= nxt_progState;
      req_ff <= (nxt_progState == PS_REQ);
      rst_ff <= (nxt_progState == PS_RESET);
    end
  end
  assign reprogramRequest = req_ff;
  assign deviceReset = rst_ff;

  // ****************************************
  // key clear timing
  // ****************************************
  // count low cycles; erase fires once when the low time is met
  // a pulse shorter than the erase time leaves the keys intact
  assign nxt_keyCnt = (!keyClear_n && secOn) ?
                      satInc(keyCnt_ff, KCNT_W'(KEY_CLEAR_CYC)) : 5'h00;
  assign keyHit = (nxt_keyCnt == KCNT_W'(KEY_CLEAR_CYC)) && !keyDone_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      keyCnt_ff <= 5'h00;
      keyDone_ff <= 1'b0;
      erase_ff <= 1'b0;
    end else if (clkEn) begin
      keyCnt_ff <= nxt_keyCnt;
      keyDone_ff <= (nxt_keyCnt == KCNT_W'(KEY_CLEAR_CYC));
      erase_ff <= keyHit;
    end
  end
  assign keyEraseStrobe = erase_ff;

  // ****************************************
  // global controls and pin takeover
  // ****************************************
  // all pin-side values registered so data outputs come from flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flopLoad_ff <= 1'b0;
      ioFloat_ff <= 1'b0;
      clkPinOut_ff <= 1'b0;
      clkPinOe_ff <= 1'b0;
      doneO_ff <= 1'b0;
      doneOe_ff <= 1'b0;
    end else if (clkEn) begin
      flopLoad_ff <= globalSetReset;
      ioFloat_ff <= globalTristate;
      clkPinOut_ff <= userCfgClockOut;
      clkPinOe_ff <= !userCfgClockTristate;
      doneO_ff <= userDoneOut;
      doneOe_ff <= !userDoneTristate;
    end
  end
  assign flopInitLoad = flopLoad_ff;
  assign userIoFloat = ioFloat_ff;
  assign cfgClockPinOut = clkPinOut_ff;
  assign cfgClockPinOe = clkPinOe_ff;
  assign donePinOut = doneO_ff;
  assign donePinOe = doneOe_ff;

  // ****************************************
  // echoes into the fabric
  // ****************************************
  // one-cycle latency is the price of sampling clocks as data
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clkEcho_ff <= 1'b0;
      dinEcho_ff <= 1'b0;
      oscEcho_ff <= 1'b0;
      cfgEcho_ff <= 1'b0;
    end else if (clkEn) begin
      clkEcho_ff <= cfgClockPinIn;
      dinEcho_ff <= flashDataPinIn;
      oscEcho_ff <= internalOscIn;
      cfgEcho_ff <= mainCfgClkIn;
    end
  end
  assign cfgClockEcho = clkEcho_ff;
  assign flashSerialDataEcho = dinEcho_ff;
  assign internalOscillatorClock = oscEcho_ff;
  assign mainConfigurationClock = cfgEcho_ff;
endmodule : sfc_startup_ctrl

// file: include/sfc_pkg.sv
// Purpose: constants for the startup fabric control block
// Assumes: single 50 MHz clock domain, clk period 20 ns
// Notes: cycle counts are derived from times given in ns
//
// Summary of operation
// - end_of_startup output mirrors internal startup flag
// - fabric startup clock steps startup sequence
// - global set reset restores flip-flop initial values
// - global tristate floats every user I/O
// - user clock output forwarded to config pin
// - clock tristate high floats config clock pin
// - done pin driven from user done value
// - done tristate high floats done pin
// - config clock echoed back to fabric
// - flash serial data passed through unaltered
// - internal oscillator clock offered to fabric
// - main configuration clock offered to fabric
// - program event raises reprogram request first
// - key_clear_n low 250 ns erases keys
// - request, acknowledge, key clear need security enable
package sfc_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int KEY_CLEAR_NS = 250;
  // least time rounds up to whole cycles
  localparam int KEY_CLEAR_CYC = (KEY_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int KCNT_W = 5;
  localparam int START_STEPS = 8;
  localparam int SCNT_W = 4;
  localparam logic PROG_SEC_DEFAULT = 1'b0;
  typedef enum logic [2:0] {PS_IDLE, PS_REQ, PS_RESET, PS_RESTART} sfc_prog_t;
endpackage : sfc_pkg

// file: verilog/sfc_edge_sync.sv
`timescale 1ns/100ps
// Purpose: sample a fabric-made clock and report its rising edges
// Assumes: input is synchronous to clk per house convention
// Notes: one register stage, pulse in the same cycle the input first reads high
module sfc_edge_sync (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic sigIn,
  output logic riseOut
);
  import sfc_pkg::*;
  logic prev_ff; // last sampled level
  // ****************************************
  // edge detect
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_ff <= 1'b0;
    end else if (clkEn) begin
      prev_ff <= sigIn;
    end
  end
  assign riseOut = clkEn & sigIn & ~prev_ff;
endmodule : sfc_edge_sync

// file: tb/sfc_fabric_model.sv
`timescale 1ns/100ps
// Purpose: fabric user logic facing the startup control block
// Assumes: one clock domain, answers sampled on clk rise
// Notes: ackWait of zero keeps acknowledge tied low
module sfc_fabric_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reprogramRequest,
  input wire logic [3:0] ackWait,
  output logic userStartupClk,
  output logic reprogramAcknowledge
);
  // ****************
  // fabric behaviour
  // ****************
  logic [3:0] waitCnt_ff; // cycles the request has stood
  // startup clock free runs, one rise every two cycles
  // acknowledge is a single pulse so a slow answer is tested too
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      userStartupClk <= 1'b0;
      reprogramAcknowledge <= 1'b0;
      waitCnt_ff <= 4'h0;
    end else begin
      userStartupClk <= ~userStartupClk;
      waitCnt_ff <= reprogramRequest ? waitCnt_ff + 4'h1 : 4'h0;
      reprogramAcknowledge <= reprogramRequest && ackWait != 4'h0 && waitCnt_ff == ackWait;
    end
  end
endmodule : sfc_fabric_model

// file: tb/sfc_startup_ctrl_properties.sv
`timescale 1ns/100ps
// Purpose: port-level checks of the startup control block
// Assumes: single clk domain, async active-low reset
// Notes: bound to every instance of the block
module sfc_startup_ctrl_properties (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic globalSetReset,
  input wire logic flopInitLoad,
  input wire logic userDoneTristate,
  input wire logic donePinOe,
  input wire logic flashDataPinIn,
  input wire logic flashSerialDataEcho,
  input wire logic reprogramRequest,
  input wire logic reprogramAcknowledge,
  input wire logic deviceReset,
  input wire logic programSecurityEnable,
  input wire logic endOfStartup,
  input wire logic keyClear_n,
  input wire logic keyEraseStrobe
);
  // **********
  // properties
  // **********
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_ack;
    reprogramRequest && reprogramAcknowledge && clkEn;
  endsequence
  property p_setReset; clkEn |=> flopInitLoad == $past(globalSetReset); endproperty
  property p_doneOe; clkEn |=> donePinOe == !$past(userDoneTristate); endproperty
  property p_flash; clkEn |=> flashSerialDataEcho == $past(flashDataPinIn); endproperty
  property p_reqHold;
    reprogramRequest && !reprogramAcknowledge && programSecurityEnable
      |=> reprogramRequest && !deviceReset;
  endproperty
  property p_ack; s_ack |=> deviceReset && !reprogramRequest ##1 !deviceReset; endproperty
  property p_secOff; !programSecurityEnable && !reprogramRequest |=> !reprogramRequest; endproperty
  // the flag is a register, so it clears on the edge after the reset pulse
  property p_startFlag; deviceReset |=> !endOfStartup; endproperty
  property p_key;
    keyEraseStrobe |-> !$past(keyClear_n, 13) && !$past(keyClear_n) &&
      $past(programSecurityEnable) ##1 !keyEraseStrobe;
  endproperty
  a_setReset: assert property (p_setReset) else $error("flop load not following set reset");
  a_doneOe: assert property (p_doneOe) else $error("done enable wrong");
  a_flash: assert property (p_flash) else $error("flash data echo wrong");
  a_reqHold: assert property (p_reqHold) else $error("request left early");
  a_ack: assert property (p_ack) else $error("no reset pulse after ack");
  a_secOff: assert property (p_secOff) else $error("request while unsecured");
  a_startFlag: assert property (p_startFlag) else $error("startup flag up after reset");
  a_key: assert property (p_key) else $error("key erase too early");
endmodule : sfc_startup_ctrl_properties
bind sfc_startup_ctrl sfc_startup_ctrl_properties sfc_startup_ctrl_properties_i (.clk, .arst_n,
  .clkEn, .globalSetReset, .flopInitLoad, .userDoneTristate, .donePinOe, .flashDataPinIn,
  .flashSerialDataEcho, .reprogramRequest, .reprogramAcknowledge, .deviceReset,
  .programSecurityEnable, .endOfStartup, .keyClear_n, .keyEraseStrobe);

// file: tb/test_sfc_startup_ctrl.sv
`timescale 1ns/100ps
// Purpose: self-checking bench of the startup control block
// Assumes: 50 MHz clk, inputs changed 1 ns after rise
// Notes: clkEn is dropped once to check that state freezes
module test_sfc_startup_ctrl;
  import sfc_pkg::*;
  // *******
  // signals
  // *******
  logic clk = 1'b0, arst_n = 1'b0, clkEn = 1'b1, programSecurityEnable = PROG_SEC_DEFAULT;
  logic globalSetReset = 1'b0, globalTristate = 1'b0, userCfgClockOut = 1'b0;
  logic userCfgClockTristate = 1'b0, userDoneOut = 1'b0, userDoneTristate = 1'b0;
  logic cfgClockPinIn = 1'b0, flashDataPinIn = 1'b0, internalOscIn = 1'b0, mainCfgClkIn = 1'b0;
  logic programPinPulse = 1'b0, scanProgramCommand = 1'b0, keyClear_n = 1'b1;
  logic [3:0] ackWait = 4'h0; // partner answer delay
  logic userStartupClk, reprogramAcknowledge, endOfStartup, flopInitLoad, userIoFloat;
  logic cfgClockPinOut, cfgClockPinOe, donePinOut, donePinOe, cfgClockEcho, flashSerialDataEcho;
  logic internalOscillatorClock, mainConfigurationClock, reprogramRequest, deviceReset;
  logic keyEraseStrobe;
  int n_fail = 0, n_tests = 0;
  sfc_startup_ctrl sfc_startup_ctrl_i (.clk, .arst_n, .clkEn, .userStartupClk, .globalSetReset,
    .globalTristate, .userCfgClockOut, .userCfgClockTristate, .userDoneOut, .userDoneTristate,
    .cfgClockPinIn, .flashDataPinIn, .internalOscIn, .mainCfgClkIn, .programPinPulse,
    .scanProgramCommand, .reprogramAcknowledge, .keyClear_n, .programSecurityEnable,
    .endOfStartup, .flopInitLoad, .userIoFloat, .cfgClockPinOut, .cfgClockPinOe, .donePinOut,
    .donePinOe, .cfgClockEcho, .flashSerialDataEcho, .internalOscillatorClock,
    .mainConfigurationClock, .reprogramRequest, .deviceReset, .keyEraseStrobe);
  sfc_fabric_model sfc_fabric_model_i (.clk, .arst_n, .reprogramRequest, .ackWait,
    .userStartupClk, .reprogramAcknowledge);
  always #10 clk = ~clk;
  // *****
  // tasks
  // *****
  task step(); @(posedge clk); #1; endtask : step
  task chk(input string n, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      $display("BAD %s expected %b seen %b", n, e, g);
      n_fail++;
    end
  endtask : chk
  // one program event, then watch long enough for restart
  task prog(input logic fire, sec, scan, input logic [3:0] w, input logic eReq, eRst);
    logic sawReq, sawRst, sawDrop;
    // a request already standing on entry counts as seen
    {sawReq, sawRst, sawDrop} = {reprogramRequest, deviceReset, !endOfStartup};
    programSecurityEnable = sec;
    ackWait = w;
    if (fire) {scanProgramCommand, programPinPulse} = {scan, !scan};
    step();
    {scanProgramCommand, programPinPulse} = 2'h0;
    for (int k = 0; k < 50; k++) begin
      {sawReq, sawRst, sawDrop} = {sawReq | reprogramRequest, sawRst | deviceReset,
        sawDrop | !endOfStartup};
      step();
    end
    chk("reprogramRequest", eReq, sawReq);
    chk("deviceReset", eRst, sawRst);
    chk("endOfStartup drop", eRst, sawDrop);
    chk("endOfStartup back", 1'b1, endOfStartup);
  endtask : prog
  // low pulse of len samples, strobe watched during and after
  task key(input int len, input logic sec, input logic e);
    logic seen;
    seen = 1'b0;
    programSecurityEnable = sec;
    keyClear_n = 1'b0;
    for (int k = 0; k < len + 3; k++) begin
      if (k == len) keyClear_n = 1'b1;
      step();
      seen = seen | keyEraseStrobe;
    end
    chk("keyEraseStrobe", e, seen);
  endtask : key
  task end_sim();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  // watchdog, run needs well under a thousand cycles
  initial begin
    #100000;
    n_fail++;
    end_sim();
  end
  // *****
  // tests
  // *****
  initial begin
    repeat (8) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (8) step();
    chk("endOfStartup early", 1'b0, endOfStartup);
    for (int k = 0; k < 40 && !endOfStartup; k++) step();
    chk("endOfStartup", 1'b1, endOfStartup);
    for (int i = 0; i < 4; i++) begin
      {globalSetReset, userCfgClockOut, userDoneOut, cfgClockPinIn, internalOscIn} = {5{i[0]}};
      {globalTristate, userCfgClockTristate, userDoneTristate, flashDataPinIn, mainCfgClkIn}
        = {5{i[1]}};
      step();
      step();
      chk("flopInitLoad", i[0], flopInitLoad);
      chk("userIoFloat", i[1], userIoFloat);
      chk("cfgClockPinOut", i[0], cfgClockPinOut);
      chk("cfgClockPinOe", !i[1], cfgClockPinOe);
      chk("donePinOut", i[0], donePinOut);
      chk("donePinOe", !i[1], donePinOe);
      chk("cfgClockEcho", i[0], cfgClockEcho);
      chk("flashSerialDataEcho", i[1], flashSerialDataEcho);
      chk("internalOscillatorClock", i[0], internalOscillatorClock);
      chk("mainConfigurationClock", i[1], mainConfigurationClock);
    end
    // clock enable low: outputs must hold while inputs move
    clkEn = 1'b0;
    {globalSetReset, userDoneOut} = 2'h0;
    step();
    step();
    chk("flopInitLoad frozen", 1'b1, flopInitLoad);
    chk("donePinOut frozen", 1'b1, donePinOut);
    chk("endOfStartup frozen", 1'b1, endOfStartup);
    clkEn = 1'b1;
    step();
    step();
    chk("flopInitLoad thawed", 1'b0, flopInitLoad);
    chk("donePinOut thawed", 1'b0, donePinOut);
    prog(1'b1, 1'b1, 1'b0, 4'h3, 1'b1, 1'b1);
    prog(1'b1, 1'b1, 1'b1, 4'h1, 1'b1, 1'b1);
    prog(1'b1, 1'b0, 1'b1, 4'h0, 1'b0, 1'b1);
    prog(1'b1, 1'b1, 1'b0, 4'h0, 1'b1, 1'b0);
    prog(1'b0, 1'b0, 1'b0, 4'h0, 1'b1, 1'b1);
    key(12, 1'b1, 1'b0);
    key(13, 1'b1, 1'b1);
    key(20, 1'b0, 1'b0);
    end_sim();
  end
endmodule : test_sfc_startup_ctrl
